//--- shared/pss_pkg.sv
// Constants and carrier types of the PLC scan sequencer
package pss_pkg;
   localparam int unsigned ADDR_W = 8;
   localparam int unsigned DATA_W = 32;
   localparam int unsigned TIME_W = 16;
   // Timing base: one tick is one millisecond
   localparam int unsigned CLK_PERIOD_NS = 8;
   localparam int unsigned TICK_NS = 1000000;
   localparam int unsigned TICK_CYCLES = TICK_NS / CLK_PERIOD_NS;
   // Scan period adjustment
   localparam int unsigned ADJ_LOG2 = 6;
   localparam logic [ADJ_LOG2-1:0] ADJ_LAST = 6'h3F;
   localparam int unsigned PCT_FULL = 100;
   localparam logic [6:0] SHARE_MAX = 7'h32;
   // Register byte addresses
   localparam logic [ADDR_W-1:0] OFS_CMD = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_CTRL = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_CONST = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_PERIOD = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_MEAN_LOGIC = 8'h14;
   localparam logic [ADDR_W-1:0] OFS_MEAN_CYCLE = 8'h18;
   // Field positions
   localparam int unsigned CTRL_PCT_BIT = 0;
   localparam int unsigned CTRL_AUTO_BIT = 1;
   localparam int unsigned CTRL_SHARE_LSB = 8;
   localparam int unsigned STAT_LDERR_BIT = 4;
   localparam int unsigned STAT_FAULT_BIT = 5;
   localparam int unsigned STAT_SHOT_BIT = 6;
   // Values after reset
   localparam logic [TIME_W-1:0] CONST_PERIOD_RST = 16'h000A;
   localparam logic [6:0] SHARE_RST = 7'h32;
   localparam logic PCT_MODE_RST = 1'b0;

   typedef enum logic [2:0] {
      CMD_NONE, CMD_RESET, CMD_RUN, CMD_STOP, CMD_PAUSE, CMD_CONT, CMD_SCAN1
   } pss_cmd_t;
   typedef enum logic [3:0] {
      MD_INIT, MD_LOAD, MD_LOAD_ERR, MD_STOP, MD_FIRST, MD_RUN, MD_TSTOP,
      MD_FAULT
   } pss_mode_t;
   typedef enum logic [2:0] {
      PH_IDLE, PH_READ, PH_LOGIC, PH_WRITE, PH_SYS, PH_WAIT
   } pss_phase_t;

   typedef struct packed {
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic wr;
      logic rd;
   } pss_bus_req_t;
   typedef struct packed {
      logic io_read;
      logic logic_run;
      logic start_level;
      logic io_write;
      logic sys_update;
   } pss_eng_req_t;
   typedef struct packed {
      logic init;
      logic load_preset;
   } pss_var_init_t;
endpackage

//--- core/pss_sequencer.sv
// Execution-state sequencer of the PLC scan engine
// Overview of operation
// - After power-on setup, enter loading without any command.
// - Loading reads and checks the program; fail to error, pass to stop.
// - With automatic start set, good loading issues a run itself.
// - Stopped idles; takes reset, single scan, continue and pause.
// - Reset from stop, run or pause returns to loading, reinitialising.
// - Unit reset keeps retentive data; reset command loads presets.
// - Every reinitialisation clears non-retentive variables to zero.
// - Run while stopped enters continuous running.
// - Single scan runs exactly one pass, then keeps the prior state.
// - First scan: read, logic above start level, write, in order.
// - Running scan: read, logic, write, update timing; repeated.
// - While running, stop goes to stopped, pause to temporary stop.
// - Temporary stop still reads and writes I/O but runs no logic.
// - From temporary stop, continue resumes running, stop stops.
// - Scan period recomputed every 64 scans from mean logic time.
// - Constant mode starts scans at the fixed period; display gets rest.
// - Constant mode: logic over half the period sets twice mean logic.
// - Percentage mode period is mean logic times 100 over the share.
// - Logic share never exceeds 50 percent; larger writes are clamped to 50.
// - At 50 percent share logic and display get equal time.
// - Major fault halts logic at once until a reset command.
//
// Decided for this implementation: the strobed register port and the address map.
module pss_sequencer #(
   parameter int unsigned TICK_CYC = pss_pkg::TICK_CYCLES
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire pss_pkg::pss_bus_req_t bus_req,
   output logic [pss_pkg::DATA_W-1:0] bus_rdata,
   output logic load_req,
   input wire logic load_done,
   input wire logic load_ok,
   output pss_pkg::pss_eng_req_t eng_req,
   input wire logic eng_done,
   input wire logic major_fault,
   output pss_pkg::pss_var_init_t var_init,
   output logic display_slot
);
   import pss_pkg::*;

   // ****************************************
   // Declarations
   // ****************************************
   pss_mode_t mode_q;
   pss_phase_t phase_q;
   pss_cmd_t cmd_pend_q;
   pss_var_init_t var_init_q;
   logic one_shot_q;
   logic load_err_q;
   logic pct_mode_q;
   logic auto_start_q;
   logic [6:0] share_q;
   logic [TIME_W-1:0] const_period_q;
   logic [TIME_W-1:0] period_q;
   logic [TIME_W-1:0] mean_logic_duration_q;
   logic [TIME_W-1:0] mean_cycle_duration_q;
   logic [TIME_W-1:0] elapsed_q;
   logic [TIME_W-1:0] logic_ticks_q;
   logic [TIME_W+ADJ_LOG2-1:0] logic_sum_q;
   logic [TIME_W+ADJ_LOG2-1:0] cycle_sum_q;
   logic [ADJ_LOG2-1:0] scan_cnt_q;
   logic [31:0] tick_cnt_q;
   logic [DATA_W-1:0] rdata_q;
   logic tick;
   logic scanning;
   logic start_scan;
   logic boundary;
   logic reset_take;
   logic fault_take;
   logic cmd_wr;
   logic do_logic;
   logic do_sys;
   logic scan_end;
   logic adjust;
   logic [TIME_W+ADJ_LOG2-1:0] logic_sum_d;
   logic [TIME_W-1:0] mean_d;
   logic [31:0] twice_mean;
   logic [31:0] pct_period;
   logic [TIME_W-1:0] period_d;
   logic [6:0] share_wr;

   // ****************************************
   // Control decode
   // ****************************************
   assign cmd_wr = bus_req.wr && (bus_req.addr == OFS_CMD);
   assign scanning = one_shot_q || (mode_q == MD_FIRST) ||
                     (mode_q == MD_RUN) || (mode_q == MD_TSTOP);
   assign start_scan = (phase_q == PH_IDLE) && scanning;
   assign boundary = (phase_q == PH_IDLE) || (phase_q == PH_WAIT);
   assign reset_take = (cmd_pend_q == CMD_RESET) &&
                       (mode_q != MD_INIT) && (mode_q != MD_LOAD);
   assign fault_take = major_fault && (mode_q != MD_INIT) &&
                       (mode_q != MD_LOAD) && (mode_q != MD_FAULT);
   assign do_logic = one_shot_q || (mode_q != MD_TSTOP);
   assign do_sys = !one_shot_q && (mode_q == MD_RUN);
   assign scan_end = eng_done && ((phase_q == PH_SYS) ||
                     ((phase_q == PH_WRITE) && !do_sys));
   assign adjust = eng_done && (phase_q == PH_SYS) &&
                   (scan_cnt_q == ADJ_LAST);
   assign tick = (tick_cnt_q == TICK_CYC - 1);

   // ****************************************
   // Engine requests
   // ****************************************
   always_comb
   begin
      eng_req = '0;
      eng_req.io_read = (phase_q == PH_READ);
      eng_req.logic_run = (phase_q == PH_LOGIC);
      eng_req.start_level = (phase_q == PH_LOGIC) &&
                            (mode_q == MD_FIRST);
      eng_req.io_write = (phase_q == PH_WRITE);
      eng_req.sys_update = (phase_q == PH_SYS);
   end

   assign load_req = (mode_q == MD_LOAD);
   assign var_init = var_init_q;
   assign display_slot = (phase_q == PH_WAIT);
   assign bus_rdata = rdata_q;

   // ****************************************
   // Execution state
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         mode_q <= MD_INIT;
         one_shot_q <= 1'b0;
         load_err_q <= 1'b0;
         var_init_q <= '0;
      end
      else
      begin
         var_init_q <= '0;
         if (mode_q == MD_INIT)
         begin
            // Unit power-up: retentive data kept
            var_init_q <= '{init: 1'b1, load_preset: 1'b0};
            mode_q <= MD_LOAD;
         end
         else if (fault_take)
         begin
            mode_q <= MD_FAULT;
            one_shot_q <= 1'b0;
         end
         else if (reset_take)
         begin
            mode_q <= MD_LOAD;
            one_shot_q <= 1'b0;
            var_init_q <= '{init: 1'b1, load_preset: 1'b1};
         end
         else if (mode_q == MD_LOAD)
         begin
            if (load_done)
            begin
               load_err_q <= !load_ok;
               if (!load_ok)
                  mode_q <= MD_LOAD_ERR;
               else if (auto_start_q)
                  mode_q <= MD_FIRST;
               else
                  mode_q <= MD_STOP;
            end
         end
         else if (one_shot_q)
         begin
            if (scan_end)
               one_shot_q <= 1'b0;
         end
         else if (mode_q == MD_FIRST)
         begin
            if (scan_end)
               mode_q <= MD_RUN;
         end
         else if (boundary)
         begin
            // Commands not listed for a state fall through unused
            case (mode_q)
               MD_STOP:
               begin
                  if (cmd_pend_q == CMD_RUN)
                     mode_q <= MD_FIRST;
                  else if (cmd_pend_q == CMD_CONT)
                     mode_q <= MD_RUN;
                  else if (cmd_pend_q == CMD_PAUSE)
                     mode_q <= MD_TSTOP;
                  else if (cmd_pend_q == CMD_SCAN1)
                     one_shot_q <= 1'b1;
               end
               MD_RUN:
               begin
                  if (cmd_pend_q == CMD_STOP)
                     mode_q <= MD_STOP;
                  else if (cmd_pend_q == CMD_PAUSE)
                     mode_q <= MD_TSTOP;
               end
               MD_TSTOP:
               begin
                  if (cmd_pend_q == CMD_CONT)
                     mode_q <= MD_RUN;
                  else if (cmd_pend_q == CMD_STOP)
                     mode_q <= MD_STOP;
                  else if (cmd_pend_q == CMD_SCAN1)
                     one_shot_q <= 1'b1;
               end
               default:
               begin
               end
            endcase
         end
      end
   end

   // ****************************************
   // Pending command
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         cmd_pend_q <= CMD_NONE;
      else if (cmd_wr)
         cmd_pend_q <= pss_cmd_t'(bus_req.wdata[2:0]);
      else if (reset_take || fault_take)
         cmd_pend_q <= CMD_NONE;
      else if (boundary && !one_shot_q && (mode_q != MD_FIRST) &&
               (mode_q != MD_LOAD) && (mode_q != MD_INIT))
         cmd_pend_q <= CMD_NONE;
   end

   // ****************************************
   // Scan phases
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (reset)
         phase_q <= PH_IDLE;
      else if (fault_take || reset_take)
         phase_q <= PH_IDLE;
      else
      begin
         case (phase_q)
            PH_IDLE:
               if (start_scan)
                  phase_q <= PH_READ;
            PH_READ:
               if (eng_done)
                  phase_q <= do_logic ? PH_LOGIC : PH_WRITE;
            PH_LOGIC:
               if (eng_done)
                  phase_q <= PH_WRITE;
            PH_WRITE:
               if (eng_done)
               begin
                  if (do_sys)
                     phase_q <= PH_SYS;
                  else if (one_shot_q)
                     phase_q <= PH_IDLE;
                  else
                     phase_q <= PH_WAIT;
               end
            PH_SYS:
               if (eng_done)
                  phase_q <= PH_WAIT;
            PH_WAIT:
               if (elapsed_q >= period_q || !scanning)
                  phase_q <= PH_IDLE;
            default:
               phase_q <= PH_IDLE;
         endcase
      end
   end

   // ****************************************
   // Time measurement
   // ****************************************
   always_ff @(posedge sys_clk)
   begin
      if (reset || start_scan || tick)
         tick_cnt_q <= '0;
      else
         tick_cnt_q <= tick_cnt_q + 32'h1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset || start_scan)
      begin
         elapsed_q <= '0;
         logic_ticks_q <= '0;
      end
      else if (tick)
      begin
         elapsed_q <= elapsed_q + 16'h1;
         if (phase_q == PH_LOGIC)
            logic_ticks_q <= logic_ticks_q + 16'h1;
      end
   end

   // ****************************************
   // Scan period adjustment
   // ****************************************
   assign logic_sum_d = logic_sum_q + {{ADJ_LOG2{1'b0}}, logic_ticks_q};
   assign mean_d = logic_sum_d[TIME_W+ADJ_LOG2-1:ADJ_LOG2];
   assign twice_mean = {15'h0, mean_d, 1'b0};
   assign pct_period = ({16'h0, mean_d} * PCT_FULL) / {25'h0, share_q};

   always_comb
   begin
      period_d = const_period_q;
      if (pct_mode_q)
         period_d = pct_period[TIME_W-1:0];
      else if (twice_mean > {16'h0, const_period_q})
         period_d = twice_mean[TIME_W-1:0];
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         scan_cnt_q <= '0;
         logic_sum_q <= '0;
         cycle_sum_q <= '0;
         mean_logic_duration_q <= '0;
         mean_cycle_duration_q <= '0;
      end
      else
      begin
         if ((phase_q == PH_WAIT) && (elapsed_q >= period_q) &&
             (mode_q == MD_RUN))
            cycle_sum_q <= cycle_sum_q + {{ADJ_LOG2{1'b0}}, elapsed_q};
         if (eng_done && (phase_q == PH_SYS))
         begin
            scan_cnt_q <= scan_cnt_q + 6'h1;
            logic_sum_q <= adjust ? '0 : logic_sum_d;
            if (adjust)
            begin
               mean_logic_duration_q <= mean_d;
               mean_cycle_duration_q <=
                  cycle_sum_q[TIME_W+ADJ_LOG2-1:ADJ_LOG2];
               cycle_sum_q <= '0;
            end
         end
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
         period_q <= CONST_PERIOD_RST;
      else if (adjust)
         period_q <= period_d;
      else if (bus_req.wr && bus_req.addr == OFS_CONST && !pct_mode_q)
         period_q <= bus_req.wdata[TIME_W-1:0];
   end

   // ****************************************
   // Register file
   // ****************************************
   always_comb
   begin
      share_wr = bus_req.wdata[CTRL_SHARE_LSB +: 7];
      if (share_wr > SHARE_MAX)
         share_wr = SHARE_MAX;
      else if (share_wr == 7'h0)
         share_wr = 7'h1;
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset)
      begin
         pct_mode_q <= PCT_MODE_RST;
         auto_start_q <= 1'b0;
         share_q <= SHARE_RST;
         const_period_q <= CONST_PERIOD_RST;
      end
      else if (bus_req.wr)
      begin
         if (bus_req.addr == OFS_CTRL)
         begin
            pct_mode_q <= bus_req.wdata[CTRL_PCT_BIT];
            auto_start_q <= bus_req.wdata[CTRL_AUTO_BIT];
            share_q <= share_wr;
         end
         else if (bus_req.addr == OFS_CONST)
            const_period_q <= bus_req.wdata[TIME_W-1:0];
      end
   end

   always_ff @(posedge sys_clk)
   begin
      if (reset || !bus_req.rd)
         rdata_q <= '0;
      else if (bus_req.addr == OFS_CTRL)
         rdata_q <= {17'h0, share_q, 6'h0, auto_start_q, pct_mode_q};
      else if (bus_req.addr == OFS_CONST)
         rdata_q <= {16'h0, const_period_q};
      else if (bus_req.addr == OFS_STATUS)
         rdata_q <= {25'h0, one_shot_q, mode_q == MD_FAULT, load_err_q,
                     mode_q};
      else if (bus_req.addr == OFS_PERIOD)
         rdata_q <= {16'h0, period_q};
      else if (bus_req.addr == OFS_MEAN_LOGIC)
         rdata_q <= {16'h0, mean_logic_duration_q};
      else if (bus_req.addr == OFS_MEAN_CYCLE)
         rdata_q <= {16'h0, mean_cycle_duration_q};
      else
         rdata_q <= '0;
   end

   // ****************************************
   // Assertions
   // ****************************************
   property p_init_to_load;
      @(posedge sys_clk) disable iff (reset)
      mode_q == MD_INIT && !reset |=> mode_q == MD_LOAD && var_init.init;
   endproperty
   a_init_to_load: assert property (p_init_to_load)
      else $error("power-on did not enter loading");

   property p_load_result;
      @(posedge sys_clk) disable iff (reset)
      mode_q == MD_LOAD && load_done && !fault_take |=>
         mode_q == ($past(load_ok) ? ($past(auto_start_q) ? MD_FIRST :
         MD_STOP) : MD_LOAD_ERR);
   endproperty
   a_load_result: assert property (p_load_result)
      else $error("wrong state after loading");

   property p_reset_cmd;
      @(posedge sys_clk) disable iff (reset)
      reset_take && !fault_take |=> mode_q == MD_LOAD && var_init.init &&
         var_init.load_preset ##1 !var_init.init;
   endproperty
   a_reset_cmd: assert property (p_reset_cmd)
      else $error("reset command not honoured");

   property p_pause_no_logic;
      @(posedge sys_clk) disable iff (reset)
      mode_q == MD_TSTOP && !one_shot_q |-> !eng_req.logic_run;
   endproperty
   a_pause_no_logic: assert property (p_pause_no_logic)
      else $error("logic ran in temporary stop");

   property p_run_stop;
      @(posedge sys_clk) disable iff (reset)
      mode_q == MD_RUN && boundary && cmd_pend_q == CMD_STOP &&
         !fault_take |=> mode_q == MD_STOP;
   endproperty
   a_run_stop: assert property (p_run_stop)
      else $error("stop ignored while running");

   property p_fault_halt;
      @(posedge sys_clk) disable iff (reset)
      fault_take |=> mode_q == MD_FAULT && !eng_req.logic_run
         ##1 !eng_req.io_read;
   endproperty
   a_fault_halt: assert property (p_fault_halt)
      else $error("major fault did not halt");

   property p_first_order;
      @(posedge sys_clk) disable iff (reset)
      mode_q == MD_FIRST && phase_q == PH_READ && eng_done && !fault_take
         && !reset_take |=> eng_req.logic_run && eng_req.start_level;
   endproperty
   a_first_order: assert property (p_first_order)
      else $error("first scan out of order");

   property p_share_cap;
      @(posedge sys_clk) disable iff (reset)
      share_q <= SHARE_MAX && share_q != 7'h0;
   endproperty
   a_share_cap: assert property (p_share_cap)
      else $error("logic share above half");

   property p_one_shot_back;
      @(posedge sys_clk) disable iff (reset)
      one_shot_q && scan_end && !fault_take && !reset_take |=>
         !one_shot_q && $stable(mode_q) && phase_q == PH_IDLE;
   endproperty
   a_one_shot_back: assert property (p_one_shot_back)
      else $error("single scan did not return");

   property p_adjust;
      @(posedge sys_clk) disable iff (reset)
      adjust |=> period_q == $past(period_d) && scan_cnt_q == 6'h0;
   endproperty
   a_adjust: assert property (p_adjust)
      else $error("period not recomputed");

   c_auto_start: cover property (@(posedge sys_clk)
      mode_q == MD_LOAD ##1 mode_q == MD_FIRST);
   c_pause: cover property (@(posedge sys_clk)
      mode_q == MD_RUN ##1 mode_q == MD_TSTOP);
   c_single: cover property (@(posedge sys_clk) one_shot_q && scan_end);
   c_adjust: cover property (@(posedge sys_clk) adjust && pct_mode_q);

endmodule // pss_sequencer

//--- testbench/pss_engine_model.sv
// Behavioural program store and scan engine facing the sequencer
module pss_engine_model
   import pss_pkg::*;
#(
   parameter int unsigned DLY = 20
) (
   input wire logic sys_clk,
   input wire logic reset,
   input wire logic load_req,
   input wire pss_pkg::pss_eng_req_t eng_req,
   output logic load_done,
   output logic eng_done
);
   timeunit 1ns;
   timeprecision 100ps;
   int unsigned cnt_q;
   logic busy;
   assign busy = |eng_req;
   // Every request takes DLY+1 cycles before its one-cycle done pulse
   always_ff @(posedge sys_clk)
   begin
      if (reset || !(busy || load_req) || eng_done || load_done)
         cnt_q <= 0;
      else
         cnt_q <= cnt_q + 1;
   end
   always_ff @(posedge sys_clk)
   begin
      eng_done <= !reset && busy && !eng_done && cnt_q == DLY;
      load_done <= !reset && load_req && !load_done && cnt_q == DLY;
   end
endmodule // pss_engine_model

//--- testbench/pss_sequencer_tb_top.sv
// Self-checking bench of the PLC scan sequencer
module pss_sequencer_tb_top;
   import pss_pkg::*;
   timeunit 1ns;
   timeprecision 100ps;
   typedef struct packed {pss_cmd_t c; logic [3:0] s;} pss_row_t;
   logic sys_clk = 1'b0;
   logic reset = 1'b1;
   logic load_ok = 1'b1;
   logic major_fault = 1'b0;
   logic preset_v = 1'b0;
   logic lg_p = 1'b0;
   pss_bus_req_t bus_req = '0;
   logic [DATA_W-1:0] bus_rdata;
   logic load_req, load_done, eng_done;
   logic display_slot;
   int ds_n = 0;
   pss_eng_req_t eng_req;
   pss_var_init_t var_init;
   int bad_count = 0;
   int checked = 0;
   int lg_n = 0;
   int io_n = 0;
   int sc_n = 0;
   int init_n = 0;
   pss_row_t rows [9] = '{
      '{CMD_PAUSE, 4'h6},
      '{CMD_CONT, 4'h5},
      '{CMD_CONT, 4'h5},
      '{CMD_PAUSE, 4'h6},
      '{CMD_STOP, 4'h3},
      '{CMD_RUN, 4'h5},
      '{CMD_STOP, 4'h3},
      '{CMD_SCAN1, 4'h3},
      '{CMD_RESET, 4'h3}};
   always #4 sys_clk = ~sys_clk;
   pss_sequencer #(.TICK_CYC(10)) dut (.sys_clk(sys_clk), .reset(reset),
      .bus_req(bus_req), .bus_rdata(bus_rdata), .load_req(load_req),
      .load_done(load_done), .load_ok(load_ok), .eng_req(eng_req),
      .eng_done(eng_done), .major_fault(major_fault), .var_init(var_init),
      .display_slot(display_slot));
   pss_engine_model #(.DLY(20)) eng (.sys_clk(sys_clk), .reset(reset),
      .load_req(load_req), .eng_req(eng_req), .load_done(load_done),
      .eng_done(eng_done));
   // Counts logic passes, output writes, full scans and reinitialisations
   always @(posedge sys_clk)
   begin
      if (eng_req.logic_run && !lg_p) lg_n++;
      lg_p = eng_req.logic_run;
      if (eng_req.io_write && eng_done) io_n++;
      if (eng_req.sys_update && eng_done) sc_n++;
      if (var_init.init) init_n++;
      if (display_slot) ds_n++;
      if (var_init.init) preset_v = var_init.load_preset;
   end
   task automatic final_report();
      $display("checks %0d mismatches %0d", checked, bad_count);
      if (bad_count == 0 && checked > 0)
         $display("Test passed");
      else
         $display("Test failed");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checked++;
      if (g !== e)
      begin
         bad_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic wr(logic [ADDR_W-1:0] a, logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      bus_req.addr <= a;
      bus_req.wdata <= d;
      bus_req.wr <= 1'b1;
      @(posedge sys_clk);
      bus_req.wr <= 1'b0;
   endtask
   task automatic rd(logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d);
      @(posedge sys_clk);
      bus_req.addr <= a;
      bus_req.rd <= 1'b1;
      @(posedge sys_clk);
      bus_req.rd <= 1'b0;
      #1 d = bus_rdata;
   endtask
   task automatic rdc(logic [ADDR_W-1:0] a, logic [31:0] m, logic [31:0] e,
      string nm);
      logic [DATA_W-1:0] v;
      rd(a, v);
      chk(nm, e, v & m);
   endtask
   task automatic cmd(pss_cmd_t c);
      wr(OFS_CMD, {29'h0, c});
   endtask
   task automatic wait_st(logic [3:0] s, string nm);
      logic [DATA_W-1:0] v;
      for (int i = 0; i < 300; i++)
      begin
         rd(OFS_STATUS, v);
         if (v[3:0] === s) break;
      end
      chk(nm, {28'h0, s}, {28'h0, v[3:0]});
   endtask
   task automatic idle_logic(int n, string nm);
      int l0;
      l0 = lg_n;
      repeat (400) @(posedge sys_clk);
      chk(nm, n, lg_n - l0);
   endtask
   initial
   begin
      #(8 * 60000);
      bad_count++;
      final_report();
   end
   initial
   begin
      logic [DATA_W-1:0] p, m;
      int i0, s0, d0;
      repeat (20) @(posedge sys_clk);
      reset <= 1'b0;
      wait_st(4'h3, "boot state");
      chk("boot init", 32'h1, init_n);
      chk("boot preset", 32'h0, {31'h0, preset_v});
      rdc(OFS_CONST, '1, 32'h0000000A, "const");
      rdc(OFS_CTRL, '1, 32'h00003200, "ctrl");
      rdc(8'h1C, '1, 32'h0, "unmapped");
      $display("test reset done");
      foreach (rows[i])
      begin
         cmd(rows[i].c);
         wait_st(rows[i].s, "row state");
      end
      chk("reset preset", 32'h1, {31'h0, preset_v});
      chk("reset init", 32'h2, init_n);
      $display("test rows done");
      cmd(CMD_PAUSE);
      wait_st(4'h6, "pause state");
      i0 = io_n;
      d0 = ds_n;
      idle_logic(0, "pause logic");
      chk("pause io", 32'h1, {31'h0, io_n > i0});
      chk("pause display", 32'h1, {31'h0, ds_n > d0});
      cmd(CMD_SCAN1);
      idle_logic(1, "one scan");
      wait_st(4'h6, "scan back");
      $display("test pause done");
      cmd(CMD_CONT);
      wait_st(4'h5, "run state");
      @(posedge sys_clk);
      major_fault <= 1'b1;
      @(posedge sys_clk);
      major_fault <= 1'b0;
      wait_st(4'h7, "fault state");
      rdc(OFS_STATUS, 32'h20, 32'h20, "fault flag");
      cmd(CMD_RUN);
      idle_logic(0, "fault logic");
      wait_st(4'h7, "fault held");
      cmd(CMD_RESET);
      wait_st(4'h3, "fault clear");
      $display("test fault done");
      @(posedge sys_clk);
      load_ok <= 1'b0;
      cmd(CMD_RESET);
      wait_st(4'h2, "load err");
      rdc(OFS_STATUS, 32'h10, 32'h10, "err flag");
      @(posedge sys_clk);
      load_ok <= 1'b1;
      wr(OFS_CTRL, 32'h00003202);
      cmd(CMD_RESET);
      wait_st(4'h5, "auto run");
      $display("test load done");
      wr(OFS_CONST, 32'h00000014);
      rdc(OFS_PERIOD, '1, 32'h00000014, "const period");
      wr(OFS_CTRL, 32'h00006301);
      rdc(OFS_CTRL, '1, 32'h00003201, "share clamp");
      s0 = sc_n;
      for (int i = 0; i < 20000 && sc_n < s0 + 66; i++) @(posedge sys_clk);
      rd(OFS_PERIOD, p);
      rd(OFS_MEAN_LOGIC, m);
      chk("pct period", m * 100 / 50, p);
      chk("half share", 32'h1, {31'h0, m != 0 && p == 2 * m});
      $display("test period done");
      final_report();
   end
endmodule // pss_sequencer_tb_top
